// File: hdl/eeprom_pkg.sv
// constants, types and reset state of the two-wire eeprom command engine
package eeprom_pkg;

  localparam logic [3:0] ID_ARRAY     = 4'hA;
  localparam logic [3:0] ID_IDENT     = 4'hB;
  localparam logic [2:0] CMD_IDENT_WR = 3'h0;
  localparam logic [2:0] CMD_LOCK     = 3'h2;
  localparam int         LOCK_BIT     = 1;
  localparam int         ADDR_W       = 16;
  localparam int         OFF_W        = 7;
  localparam logic [7:0] PAGE_BYTES   = 8'h80;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam int         FIFO_DEPTH   = 4;
  localparam int         TIMER_W      = 20;

  typedef enum logic [3:0] {
    S_IDLE, S_DEV, S_WHI, S_WLO, S_WDATA, S_ACK, S_RDATA, S_MACK, S_IGNORE
  } bus_state_t;

  typedef struct packed {
    logic              ident;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } prog_word_t;

  typedef struct packed {
    bus_state_t        state;
    bus_state_t        ret;
    logic [1:0]        scl_sy;
    logic [1:0]        sda_sy;
    logic              scl_d;
    logic              sda_d;
    logic [1:0]        wp_sy;
    logic [1:0][2:0]   sel_sy;
    logic [3:0]        bits;
    logic [7:0]        shreg;
    logic              is_ident;
    logic [2:0]        cmd;
    logic [ADDR_W-1:0] addr;
    logic              got_data;
    logic              pend_lock;
    logic [127:0]      vmask;
    logic              busy;
    logic [TIMER_W-1:0] timer;
    logic [7:0]        scan;
    logic              phase;
    logic              lock;
    logic              sda_oe_n;
    logic              sda_o;
  } eng_state_t;

  localparam eng_state_t ST_RESET = '{state: S_IDLE, ret: S_IDLE, scl_sy: 2'h3, sda_sy: 2'h3,
                                      scl_d: 1'b1, sda_d: 1'b1, sda_oe_n: 1'b1, default: '0};

endpackage

// File: hdl/ram_1w1r.sv
// byte memory with one write port and one registered read port
`timescale 1ns/1ps
module ram_1w1r #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock
  input  logic          clk,
  // write port
  input  logic          we,
  input  logic [AW-1:0] waddr,
  input  logic [DW-1:0] wdata,
  // read port
  input  logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_ff <= mem[raddr];
  end

  assign rdata = rdata_ff;

endmodule // ram_1w1r

// File: hdl/prog_fifo.sv
// small fifo between the page latch and the array write port
`timescale 1ns/1ps
module prog_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  logic         clk,
  input  logic         rst,
  // fill side
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  // drain side
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0]                wp;
    logic [PW:0]                rp;
    logic [DEPTH-1:0][W-1:0]    mem;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;

  assign out_valid = st_ff.wp != st_ff.rp;
  assign in_ready  = st_ff.wp != {~st_ff.rp[PW], st_ff.rp[PW-1:0]};
  assign out_data  = st_ff.mem[st_ff.rp[PW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (in_valid && in_ready) begin
      nxt_st.mem[st_ff.wp[PW-1:0]] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // prog_fifo

// File: hdl/eeprom_engine.sv
// two-wire eeprom target: command decode, page latch, self-timed program, reads
`timescale 1ns/1ps
module eeprom_engine
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = 25000
) (
  // clock and reset
  input  logic ref_clk,
  input  logic rst,
  // two-wire bus pins
  input  logic scl_in,
  input  logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // straps and protection
  input  logic write_protect,
  input  logic select_input_2,
  input  logic select_input_1,
  input  logic select_input_0,
  // status
  output logic busy,
  output logic ident_locked
);

  // lock cell powers up clear and survives rst
  eng_state_t st_ff = ST_RESET;
  eng_state_t nxt_st;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       byte_end;
  logic       commit_ok;
  logic       dev_match;
  logic       byte_ok;
  logic       lock_cmd;
  logic       stage_we;
  logic       scan_done;
  logic [7:0] b;
  logic [7:0] rd_byte;
  logic [7:0] arr_rdata;
  logic [7:0] id_rdata;
  logic [7:0] stage_rdata;
  prog_word_t push_word;
  prog_word_t pop_word;
  logic       push_valid;
  logic       push_ready;
  logic       pop_valid;
  logic       pop_ready;
  logic [$bits(prog_word_t)-1:0] pop_bits;

  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:OFF_W], a[OFF_W-1:0] + 7'h01};
  endfunction

  assign b         = st_ff.shreg;
  assign scl_rise  = st_ff.scl_sy[1] & ~st_ff.scl_d;
  assign scl_fall  = ~st_ff.scl_sy[1] & st_ff.scl_d;
  assign bus_start = st_ff.scl_sy[1] & st_ff.scl_d & st_ff.sda_d & ~st_ff.sda_sy[1];
  assign bus_stop  = st_ff.scl_sy[1] & st_ff.scl_d & ~st_ff.sda_d & st_ff.sda_sy[1];
  assign byte_end  = ~st_ff.busy & ~bus_start & ~bus_stop & scl_fall & (st_ff.bits == BYTE_BITS);
  assign commit_ok = ~st_ff.busy & bus_stop & (st_ff.state == S_WDATA) & (st_ff.bits == 4'h1) & st_ff.got_data;
  assign dev_match = ((b[7:4] == ID_ARRAY) | (b[7:4] == ID_IDENT)) & (b[3:1] == st_ff.sel_sy[1]);
  assign lock_cmd  = st_ff.is_ident & (st_ff.cmd == CMD_LOCK);
  assign scan_done = st_ff.scan == PAGE_BYTES;
  assign rd_byte   = st_ff.is_ident ? id_rdata : arr_rdata;

  // data byte acceptance
  always_comb begin
    if (!st_ff.is_ident) begin
      byte_ok = ~st_ff.wp_sy[1];
    end else if (st_ff.cmd == CMD_IDENT_WR) begin
      byte_ok = ~st_ff.wp_sy[1] & ~st_ff.lock;
    end else if (st_ff.cmd == CMD_LOCK) begin
      byte_ok = ~st_ff.wp_sy[1] & ~st_ff.lock & b[LOCK_BIT];
    end else begin
      byte_ok = 1'b0;
    end
  end

  assign stage_we = byte_end & (st_ff.state == S_WDATA) & byte_ok & ~lock_cmd;

  // program path: page latch scan into fifo, fifo paced into the arrays
  assign push_valid = st_ff.busy & st_ff.phase & ~scan_done & st_ff.vmask[st_ff.scan[6:0]];
  assign push_word  = '{ident: st_ff.is_ident,
                        addr:  st_ff.is_ident ? {9'h000, st_ff.scan[6:0]} : {st_ff.addr[15:7], st_ff.scan[6:0]},
                        data:  stage_rdata};
  assign pop_ready  = st_ff.busy & (st_ff.timer[0] | (st_ff.timer == '0));
  assign pop_word   = prog_word_t'(pop_bits);

  ram_1w1r #(.AW(OFF_W), .DW(8)) u_stage (
    .clk   (ref_clk),
    .we    (stage_we),
    .waddr (st_ff.addr[6:0]),
    .wdata (b),
    .raddr (st_ff.scan[6:0]),
    .rdata (stage_rdata)
  );

  prog_fifo #(.W($bits(prog_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_bits)
  );

  ram_1w1r #(.AW(ADDR_W), .DW(8)) u_array (
    .clk   (ref_clk),
    .we    (pop_valid & pop_ready & ~pop_word.ident),
    .waddr (pop_word.addr),
    .wdata (pop_word.data),
    .raddr (st_ff.addr),
    .rdata (arr_rdata)
  );

  ram_1w1r #(.AW(OFF_W), .DW(8)) u_ident (
    .clk   (ref_clk),
    .we    (pop_valid & pop_ready & pop_word.ident),
    .waddr (pop_word.addr[6:0]),
    .wdata (pop_word.data),
    .raddr (st_ff.addr[6:0]),
    .rdata (id_rdata)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_sy = {st_ff.scl_sy[0], scl_in};
    nxt_st.sda_sy = {st_ff.sda_sy[0], sda_in};
    nxt_st.scl_d  = st_ff.scl_sy[1];
    nxt_st.sda_d  = st_ff.sda_sy[1];
    nxt_st.wp_sy  = {st_ff.wp_sy[0], write_protect};
    nxt_st.sel_sy = {st_ff.sel_sy[0], {select_input_2, select_input_1, select_input_0}};
    nxt_st.sda_o  = 1'b0;
    if (st_ff.busy) begin
      // bus is deaf while programming, so polling gets no ack
      nxt_st.state    = S_IDLE;
      nxt_st.sda_oe_n = 1'b1;
      if (st_ff.timer != '0) begin
        nxt_st.timer = st_ff.timer - 1'b1;
      end
      if (!scan_done) begin
        if (!st_ff.phase) begin
          nxt_st.phase = 1'b1;
        end else if (!st_ff.vmask[st_ff.scan[6:0]] || push_ready) begin
          nxt_st.phase = 1'b0;
          nxt_st.scan  = st_ff.scan + 8'h01;
        end
      end
      if (scan_done && st_ff.pend_lock) begin
        nxt_st.lock      = 1'b1;
        nxt_st.pend_lock = 1'b0;
      end
      if ((st_ff.timer == '0) && scan_done && !st_ff.pend_lock && !pop_valid) begin
        nxt_st.busy  = 1'b0;
        nxt_st.vmask = '0;
      end
    end else if (bus_start) begin
      // counter is kept, so a repeated start after a dummy write reads there
      nxt_st.state     = S_DEV;
      nxt_st.bits      = '0;
      nxt_st.vmask     = '0;
      nxt_st.got_data  = 1'b0;
      nxt_st.pend_lock = 1'b0;
      nxt_st.sda_oe_n  = 1'b1;
    end else if (bus_stop) begin
      if (commit_ok) begin
        nxt_st.busy  = 1'b1;
        nxt_st.timer = TIMER_W'(PROG_CYCLES);
        nxt_st.scan  = '0;
        nxt_st.phase = 1'b0;
      end else begin
        nxt_st.vmask     = '0;
        nxt_st.pend_lock = 1'b0;
      end
      nxt_st.state    = S_IDLE;
      nxt_st.sda_oe_n = 1'b1;
    end else begin
      case (st_ff.state)
        S_DEV, S_WHI, S_WLO, S_WDATA: begin
          if (scl_rise) begin
            nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sda_sy[1]};
            nxt_st.bits  = st_ff.bits + 4'h1;
          end
          if (byte_end) begin
            nxt_st.bits     = '0;
            nxt_st.state    = S_ACK;
            nxt_st.sda_oe_n = 1'b0;
            case (st_ff.state)
              S_DEV: begin
                if (dev_match) begin
                  nxt_st.is_ident = b[4];
                  nxt_st.ret      = b[0] ? S_RDATA : S_WHI;
                end else begin
                  nxt_st.state    = S_IGNORE;
                  nxt_st.sda_oe_n = 1'b1;
                end
              end
              S_WHI: begin
                nxt_st.cmd        = b[3:1];
                nxt_st.addr[15:8] = b;
                nxt_st.ret        = S_WLO;
              end
              S_WLO: begin
                nxt_st.addr[7:0] = b;
                nxt_st.ret       = S_WDATA;
              end
              default: begin
                nxt_st.ret      = S_WDATA;
                nxt_st.sda_oe_n = ~byte_ok;
                nxt_st.got_data = byte_ok;
                if (stage_we) begin
                  nxt_st.vmask[st_ff.addr[6:0]] = 1'b1;
                  nxt_st.addr = page_inc(st_ff.addr);
                end
                if (lock_cmd) begin
                  nxt_st.pend_lock = byte_ok;
                end
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            nxt_st.state    = st_ff.ret;
            nxt_st.bits     = '0;
            nxt_st.sda_oe_n = 1'b1;
            if (st_ff.ret == S_RDATA) begin
              nxt_st.shreg    = {rd_byte[6:0], 1'b0};
              nxt_st.sda_oe_n = rd_byte[7];
              nxt_st.bits     = 4'h1;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (st_ff.bits == BYTE_BITS) begin
              nxt_st.sda_oe_n = 1'b1;
              nxt_st.state    = S_MACK;
              nxt_st.addr     = st_ff.is_ident ? page_inc(st_ff.addr) : st_ff.addr + 16'h0001;
            end else begin
              nxt_st.sda_oe_n = st_ff.shreg[7];
              nxt_st.shreg    = {st_ff.shreg[6:0], 1'b0};
              nxt_st.bits     = st_ff.bits + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            nxt_st.state = st_ff.sda_sy[1] ? S_IGNORE : S_ACK;
            nxt_st.ret   = S_RDATA;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff      <= ST_RESET;
      st_ff.lock <= st_ff.lock;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sda_out      = st_ff.sda_o;
  assign sda_oe_n     = st_ff.sda_oe_n;
  assign busy         = st_ff.busy;
  assign ident_locked = st_ff.lock;

  sequence s_commit_stop;
    commit_ok;
  endsequence
  sequence s_prog_hold;
    st_ff.busy [*8];
  endsequence
  sequence s_ack_held;
    !st_ff.sda_oe_n [*2];
  endsequence

  property p_commit;
    s_commit_stop |=> s_prog_hold;
  endproperty
  a_commit: assert property (p_commit) else $error("program cycle not held after stop");

  property p_stray_stop;
    (bus_stop && !st_ff.busy && !commit_ok) |=> !st_ff.busy;
  endproperty
  a_stray_stop: assert property (p_stray_stop) else $error("stray stop started programming");

  property p_busy_mute;
    st_ff.busy |-> (st_ff.sda_oe_n && (st_ff.state == S_IDLE));
  endproperty
  a_busy_mute: assert property (p_busy_mute) else $error("bus answered while programming");

  property p_wp_nack;
    (byte_end && (st_ff.state == S_WDATA) && st_ff.wp_sy[1]) |=> st_ff.sda_oe_n && !$past(stage_we);
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("protected data byte acknowledged");

  property p_page_wrap;
    stage_we |=> (st_ff.addr[15:7] == $past(st_ff.addr[15:7])) && (st_ff.addr[6:0] == $past(st_ff.addr[6:0]) + 7'h01);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page address did not wrap in page");

  property p_rd_next;
    (byte_end && (st_ff.state == S_RDATA) && !st_ff.is_ident) |=> st_ff.addr == $past(st_ff.addr) + 16'h0001;
  endproperty
  a_rd_next: assert property (p_rd_next) else $error("read counter not advanced by one");

  property p_lock_hold;
    st_ff.lock |=> st_ff.lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock flag cleared");

  property p_locked_nack;
    (byte_end && (st_ff.state == S_WDATA) && st_ff.is_ident && st_ff.lock) |=> st_ff.sda_oe_n;
  endproperty
  a_locked_nack: assert property (p_locked_nack) else $error("locked page byte acknowledged");

  property p_dev_reject;
    (byte_end && (st_ff.state == S_DEV) && !dev_match) |=> (st_ff.state == S_IGNORE) && st_ff.sda_oe_n;
  endproperty
  a_dev_reject: assert property (p_dev_reject) else $error("foreign address not rejected");

  property p_dev_ack;
    (byte_end && (st_ff.state == S_DEV) && dev_match) |=> s_ack_held;
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("matching address not acknowledged");

endmodule // eeprom_engine

// File: tb/bus_ctrl_model.sv
// two-wire bus controller model: clocks the bus and drives data open-drain style
`timescale 1ns/1ps
module bus_ctrl_model (
  // clock
  input  wire logic ref_clk,
  // resolved data wire
  input  wire logic sda_wire,
  // driven bus lines, data 1 means released to the pull-up
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one clock pulse: data changes one cycle after the fall, sampled late in the high phase
  task automatic clk_bit(input logic b, output logic r);
    tick(1);
    scl <= 1'b0;
    tick(1);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda_wire;
  endtask

  task automatic start_cond();
    logic r;
    clk_bit(1'b1, r);
    tick(1);
    sda_drv <= 1'b0;
    tick(4);
  endtask

  // stop in the clock slot right after the previous ninth clock
  task automatic stop_cond();
    logic r;
    clk_bit(1'b0, r);
    tick(1);
    sda_drv <= 1'b1;
    tick(4);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~more, r);
  endtask
endmodule // bus_ctrl_model

// File: tb/eeprom_engine_bench.sv
// self-checking bench of the eeprom command engine
`timescale 1ns/1ps
module eeprom_engine_bench;
  import eeprom_pkg::*;
  localparam int         PROG  = 600;
  localparam int         LIMIT = 60000;
  localparam logic [2:0] SEL   = 3'h5;
  logic ref_clk, rst, scl, sda_drv, sda_wire;
  logic sda_out, sda_oe_n, write_protect, busy, ident_locked;
  int   fail_count, checks_done;
  int   cycles = 0;

  // open-drain wire with pull-up
  assign sda_wire = sda_drv & (sda_oe_n | sda_out);

  eeprom_engine #(.PROG_CYCLES(PROG)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .write_protect(write_protect), .select_input_2(SEL[2]), .select_input_1(SEL[1]),
    .select_input_0(SEL[0]), .busy(busy), .ident_locked(ident_locked));
  bus_ctrl_model i_ctrl (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(8'(busy), 8'h0);
  endtask

  // start (or repeated start) and address byte
  task automatic dev(input logic [3:0] id, input logic rw, input logic exp_ack);
    logic a;
    i_ctrl.start_cond();
    i_ctrl.send_byte({id, SEL, rw}, a);
    chk(8'(a), 8'(exp_ack));
  endtask

  task automatic set_addr(input logic [3:0] id, input logic [15:0] ad);
    logic a;
    dev(id, 1'b0, 1'b1);
    i_ctrl.send_byte(ad[15:8], a);
    chk(8'(a), 8'h1);
    i_ctrl.send_byte(ad[7:0], a);
    chk(8'(a), 8'h1);
  endtask

  task automatic wr(input logic [3:0] id, input logic [15:0] ad, input logic [7:0] d[$], input logic dack,
                    input logic commit);
    logic a;
    set_addr(id, ad);
    foreach (d[i]) begin
      i_ctrl.send_byte(d[i], a);
      chk(8'(a), 8'(dack));
    end
    i_ctrl.stop_cond();
    i_ctrl.tick(2);
    chk(8'(busy), 8'(commit));
    if (commit) begin
      dev(ID_ARRAY, 1'b0, 1'b0);
      i_ctrl.stop_cond();
      wait_idle();
      dev(ID_ARRAY, 1'b0, 1'b1);
      i_ctrl.stop_cond();
    end
  endtask

  task automatic rd(input logic [3:0] id, input logic [7:0] exp[$]);
    logic [7:0] q;
    dev(id, 1'b1, 1'b1);
    foreach (exp[i]) begin
      i_ctrl.recv_byte(i < exp.size() - 1, q);
      chk(q, exp[i]);
    end
    i_ctrl.stop_cond();
  endtask

  task automatic t_basic();
    logic a;
    wr(ID_ARRAY, 16'h1234, {8'h5A, 8'hA5}, 1'b1, 1'b1);
    set_addr(ID_ARRAY, 16'h1234);
    rd(ID_ARRAY, {8'h5A});
    rd(ID_ARRAY, {8'hA5});
    dev(4'h9, 1'b1, 1'b0);
    i_ctrl.stop_cond();
    i_ctrl.start_cond();
    i_ctrl.send_byte({ID_ARRAY, ~SEL, 1'b1}, a);
    chk(8'(a), 8'h0);
    i_ctrl.stop_cond();
    $display("done basic");
  endtask

  task automatic t_protect();
    logic a;
    write_protect <= 1'b1;
    wr(ID_ARRAY, 16'h1234, {8'hC3, 8'h3C}, 1'b0, 1'b0);
    set_addr(ID_ARRAY, 16'h1234);
    rd(ID_ARRAY, {8'h5A, 8'hA5});
    write_protect <= 1'b0;
    // acked data byte, then a stop in the middle of the next byte must not program
    set_addr(ID_ARRAY, 16'h1234);
    i_ctrl.send_byte(8'hC3, a);
    chk(8'(a), 8'h1);
    for (int i = 0; i < 4; i++) i_ctrl.clk_bit(1'b0, a);
    i_ctrl.stop_cond();
    i_ctrl.tick(2);
    chk(8'(busy), 8'h0);
    set_addr(ID_ARRAY, 16'h1234);
    rd(ID_ARRAY, {8'h5A});
    $display("done protect");
  endtask

  task automatic t_page();
    logic [7:0] d[$];
    for (int i = 0; i < 130; i++) d.push_back(8'(i) + 8'h40);
    wr(ID_ARRAY, 16'h027E, d, 1'b1, 1'b1);
    set_addr(ID_ARRAY, 16'h027E);
    rd(ID_ARRAY, {8'hC0, 8'hC1});
    set_addr(ID_ARRAY, 16'h0200);
    rd(ID_ARRAY, {8'h42});
    $display("done page");
  endtask

  task automatic t_wrap();
    wr(ID_ARRAY, 16'hFFFF, {8'hE7}, 1'b1, 1'b1);
    wr(ID_ARRAY, 16'h0000, {8'h3C}, 1'b1, 1'b1);
    set_addr(ID_ARRAY, 16'hFFFF);
    rd(ID_ARRAY, {8'hE7, 8'h3C});
    $display("done wrap");
  endtask

  task automatic t_ident();
    wr(ID_IDENT, 16'hF185, {8'h77}, 1'b1, 1'b1);
    set_addr(ID_IDENT, 16'h0005);
    rd(ID_IDENT, {8'h77});
    set_addr(ID_IDENT, 16'h0000);
    rd(ID_ARRAY, {8'h3C});
    wr(ID_IDENT, 16'h0400, {8'hFD}, 1'b0, 1'b0);
    chk(8'(ident_locked), 8'h0);
    wr(ID_IDENT, 16'hF5FF, {8'h02}, 1'b1, 1'b1);
    chk(8'(ident_locked), 8'h1);
    wr(ID_IDENT, 16'h0400, {8'hFF}, 1'b0, 1'b0);
    wr(ID_IDENT, 16'h0005, {8'h11}, 1'b0, 1'b0);
    set_addr(ID_IDENT, 16'h0005);
    rd(ID_IDENT, {8'h77});
    rst <= 1'b1;
    i_ctrl.tick(5);
    rst <= 1'b0;
    i_ctrl.tick(4);
    chk(8'(ident_locked), 8'h1);
    // counter restarts at zero after reset, array content survives
    rd(ID_ARRAY, {8'h3C});
    $display("done ident");
  endtask

  initial begin
    rst           = 1'b1;
    write_protect = 1'b0;
    fail_count    = 0;
    checks_done   = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_basic();
    t_protect();
    t_page();
    t_wrap();
    t_ident();
    report_and_stop();
  end
endmodule // eeprom_engine_bench
